// file: rtl/tks_pkg.sv
// tks_pkg: constants for the touch key scan control block.
// assumes a 32-bit APB slave with one register per aligned word.
package tks_pkg;
	localparam int          NUM_MOD       = 6;
	localparam int          MEM_AW        = 5;
	// byte offsets of the register map
	localparam logic [11:0] OFS_PRELOAD   = 12'h000;
	localparam logic [11:0] OFS_CTRL      = 12'h004;
	localparam logic [11:0] OFS_CLKCFG    = 12'h008;
	localparam logic [11:0] OFS_REF_LO    = 12'h00C;
	localparam logic [11:0] OFS_REF_HI    = 12'h010;
	localparam logic [11:0] OFS_MOD_BASE  = 12'h040;
	localparam logic [11:0] OFS_MOD_STEP  = 12'h020;
	localparam logic [11:0] OFS_MOD_END   = 12'h100;
	localparam logic [11:0] OFS_MEM_BASE  = 12'h200;
	localparam logic [11:0] OFS_MEM_END   = 12'h280;
	// per-module word index
	localparam logic [2:0]  MI_FREQ_LO    = 3'h0;
	localparam logic [2:0]  MI_FREQ_HI    = 3'h1;
	localparam logic [2:0]  MI_CAP_LO     = 3'h2;
	localparam logic [2:0]  MI_CAP_HI     = 3'h3;
	localparam logic [2:0]  MI_OSC        = 3'h4;
	localparam logic [2:0]  MI_KEYEN      = 3'h5;
	localparam logic [2:0]  MI_SEQ        = 3'h6;
	// control register bits, clock config shared bit, key enable slot clock bit, masks and reset values
	localparam int          B_RAMC        = 7;
	localparam int          B_SLOTOV      = 6;
	localparam int          B_START       = 5;
	localparam int          B_FREQOV      = 4;
	localparam int          B_REFOV       = 3;
	localparam int          B_MODE        = 1;
	localparam int          B_BUSY        = 0;
	localparam int          B_SHARED      = 4;
	localparam int          B_TSS         = 7;
	localparam logic [7:0]  CTRL_WMASK    = 8'hFA;
	localparam logic [7:0]  CLKCFG_RST    = 8'h03;
	localparam logic [7:0]  PRELOAD_RST   = 8'h00;
	localparam logic [5:0]  OSC_WMASK     = 6'h3F;
	localparam logic [7:0]  KEYEN_WMASK   = 8'hBF;
	localparam logic [4:0]  UNIT_LAST     = 5'h1F;
	localparam logic [1:0]  SLOT_LAST     = 2'h3;
	localparam int          SYS_DIV       = 4;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SLOT_END} tks_state_t;
endpackage : tks_pkg

// file: rtl/tks_scan_ctrl.sv
// tks_scan_ctrl: register file and scan sequencer of the touch key scanner.
// assumes oscillator edge inputs are asynchronous pulses and the clock is the system clock.
//
// Function
// R01 - one register set per module zero to five plus shared function registers
// R02 - five-bit prescaler makes one slot unit of 32 slot clocks
// R03 - slot counter starts at preload, overflows after 256 minus preload units
// R04 - access select 0 gives memory to host, 1 to scanner
// R05 - auto scan owns memory regardless of access select until busy falls
// R06 - software should set access select before an auto scan
// R07 - hardware slot overflow also raises interrupt; software set does not
// R08 - auto scan mid overflow keeps flag clear, clears counters, reloads slot counter
// R09 - auto scan completion sets flags, stops oscillators and counters
// R10 - manual overflow sets flags, stops oscillators and counters
// R11 - clearing start clears frequency, reference and unit counters, not slot counter
// R12 - start rising edge enables counters and oscillators
// R13 - any frequency counter overflow sets sticky bit 4
// R14 - reference counter overflow sets sticky bit 3
// R15 - control bit 1 selects auto (0) or manual (1) scan
// R16 - manual scan software loads capacitor first, reads counts after
// R17 - auto scan fetches capacitor settings and stores counts to memory
// R18 - auto scan follows the key sequence fields until all keys done
// R19 - busy sets when start rises
// R20 - busy clears at manual overflow or auto completion
// R21 - control bit 2 reads zero
// R22 - shared select uses module 0 slot counter when 1
// R23 - slot clock source: reference oscillator or system clock over four
// R24 - auto scan clears frequency counters after slots 0..2, keeps after 3
// R25 - auto scan loads next slot capacitor value at slot end
// R26 - slot counter steps on unit rollover, overflows from all ones
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tks_scan_ctrl
	import tks_pkg::*;
(
	// apb
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// oscillator edges from the pads
	input  wire logic [NUM_MOD-1:0] key_osc_edge,
	input  wire logic [NUM_MOD-1:0] ref_osc_edge,
	// oscillator controls
	output logic      [NUM_MOD-1:0] key_osc_run,
	output logic      [NUM_MOD-1:0] ref_osc_run,
	output logic      [NUM_MOD-1:0] [1:0] key_select,
	output logic      [NUM_MOD-1:0] [9:0] ref_cap_setting,
	// interrupt request
	output logic                    module_irq_request
);
	// register file
	logic [7:0]               preload_r;
	logic [7:0]               clkcfg_r;
	logic [7:0]               ctrl_r;
	logic                     busy_r;
	logic                     auto_r;
	logic [15:0]              ref_cnt_r;
	logic [NUM_MOD-1:0][15:0] freq_r;
	logic [NUM_MOD-1:0][9:0]  cap_r;
	logic [NUM_MOD-1:0][5:0]  osc_r;
	logic [NUM_MOD-1:0][7:0]  keyen_r;
	logic [NUM_MOD-1:0][7:0]  seq_r;
	// scan timing
	logic [NUM_MOD-1:0][4:0]  unit_r;
	logic [NUM_MOD-1:0][7:0]  slot_r;
	logic [NUM_MOD-1:0]       slot_ov;
	logic [1:0]               slot_idx_r;
	logic [1:0]               div_r;
	logic [7:0]               mem_r [0:(1<<MEM_AW)-1];
	// pad synchronisers
	logic [NUM_MOD-1:0]       key_s1_r;
	logic [NUM_MOD-1:0]       key_s2_r;
	logic [NUM_MOD-1:0]       key_s3_r;
	logic [NUM_MOD-1:0]       ref_s1_r;
	logic [NUM_MOD-1:0]       ref_s2_r;
	logic [NUM_MOD-1:0]       ref_s3_r;
	logic [NUM_MOD-1:0]       key_tick;
	logic [NUM_MOD-1:0]       ref_tick;
	// sequencer
	logic                     sys_tick;
	logic                     run;
	logic                     sel_ov;
	logic                     auto_done;
	logic                     slot_end;
	logic                     stop_scan;
	logic                     irq_r;
	tks_state_t               state_r;
	tks_state_t               state_nxt;

	// apb decode
	logic                     wr_en;
	logic                     hit;
	logic [7:0]               rd_byte;
	logic                     start_wr_rise;
	logic                     start_wr_fall;
	logic                     scanner_owns;

	function automatic logic in_mod(input logic [11:0] a);
		in_mod = (a >= OFS_MOD_BASE) && (a < OFS_MOD_END);
	endfunction : in_mod

	function automatic logic [2:0] mod_of(input logic [11:0] a);
		logic [11:0] d;
		d      = a - OFS_MOD_BASE;
		mod_of = d[7:5];
	endfunction : mod_of

	assign wr_en   = psel & penable & pwrite;
	assign pready  = 1'b1;
	// counters are gated by the sequencer state, which tracks busy edge for edge
	assign run     = (state_r != ST_IDLE);
	assign sys_tick = (div_r == 2'(SYS_DIV - 1));
	// write to start in this access, seen before the register changes
	assign start_wr_rise = wr_en && (paddr == OFS_CTRL) && pwdata[B_START] && !ctrl_r[B_START];
	assign start_wr_fall = wr_en && (paddr == OFS_CTRL) && !pwdata[B_START] && ctrl_r[B_START];
	assign scanner_owns  = (busy_r && auto_r) || ctrl_r[B_RAMC];          // [R04] [R05]

	// pad edges pass two flops before the third flop used for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_s1_r <= '0;
			key_s2_r <= '0;
			key_s3_r <= '0;
			ref_s1_r <= '0;
			ref_s2_r <= '0;
			ref_s3_r <= '0;
		end else begin
			key_s1_r <= key_osc_edge;
			key_s2_r <= key_s1_r;
			key_s3_r <= key_s2_r;
			ref_s1_r <= ref_osc_edge;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
		end
	end
	assign key_tick = key_s2_r & ~key_s3_r;
	assign ref_tick = ref_s2_r & ~ref_s3_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) div_r <= '0;
		else          div_r <= div_r + 2'h1;
	end

	// per-module slot timing
	genvar g;
	generate
		for (g = 0; g < NUM_MOD; g++) begin : g_mod
			logic tsc;
			assign tsc = osc_sel(g) ? sys_tick : ref_tick[g];             // [R23]
			assign slot_ov[g] = run && tsc && (unit_r[g] == UNIT_LAST) && (slot_r[g] == 8'hFF);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					unit_r[g] <= '0;
					slot_r[g] <= PRELOAD_RST;
				end else if (start_wr_rise) begin
					unit_r[g] <= '0;
					slot_r[g] <= preload_r;                                 // [R03] [R12]
				end else if (start_wr_fall) begin
					unit_r[g] <= '0;                                        // [R11]
				end else if (slot_end) begin
					unit_r[g] <= '0;                                        // [R08]
					slot_r[g] <= preload_r;
				end else if (run && tsc) begin
					unit_r[g] <= unit_r[g] + 5'h1;                          // [R02]
					if (unit_r[g] == UNIT_LAST)
						slot_r[g] <= slot_r[g] + 8'h01;                     // [R26]
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					freq_r[g] <= '0;
				else if (start_wr_fall || start_wr_rise)
					freq_r[g] <= '0;                                        // [R11]
				else if (slot_end && slot_idx_r != SLOT_LAST)
					freq_r[g] <= '0;                                        // [R08] [R24]
				else if (run && key_tick[g] && keyen_r[g][4])
					freq_r[g] <= freq_r[g] + 16'h0001;
			end
			assign key_osc_run[g]     = run & keyen_r[g][4];               // [R09] [R10] [R12]
			assign ref_osc_run[g]     = run & keyen_r[g][5];
			assign key_select[g]      = auto_r ? seq_r[g][2*slot_idx_r +: 2] : 2'h0; // [R18]
			assign ref_cap_setting[g] = cap_r[g];
		end
	endgenerate

	function automatic logic osc_sel(input int m);
		osc_sel = keyen_r[m][B_TSS];
	endfunction : osc_sel

	assign sel_ov    = clkcfg_r[B_SHARED] ? slot_ov[0] : (|slot_ov);   // [R22]
	assign auto_done = auto_r && sel_ov && (slot_idx_r == SLOT_LAST);
	assign slot_end  = auto_r && sel_ov && (slot_idx_r != SLOT_LAST);   // [R08]
	assign stop_scan = run && sel_ov && (!auto_r || auto_done);         // [R09] [R10]

	// scan sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:     if (start_wr_rise) state_nxt = ST_RUN;
			ST_RUN:      if (start_wr_fall || stop_scan) state_nxt = ST_IDLE;
			             else if (slot_end) state_nxt = ST_SLOT_END;
			// a stop written in the reload cycle must not be lost
			ST_SLOT_END: if (start_wr_fall) state_nxt = ST_IDLE;
			             else state_nxt = ST_RUN;
			default:     state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// busy follows the written start edge, not the stored start bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_r <= 1'b0;
		else if (start_wr_rise)
			busy_r <= 1'b1;                                                 // [R19]
		else if (stop_scan || start_wr_fall)
			busy_r <= 1'b0;                                                 // [R20]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			auto_r <= 1'b0;
		else if (start_wr_rise)
			auto_r <= !pwdata[B_MODE];                                      // [R05] [R15]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			slot_idx_r <= '0;
		else if (start_wr_rise)
			slot_idx_r <= '0;
		else if (slot_end)
			slot_idx_r <= slot_idx_r + 2'h1;                                // [R18]
	end

	// reference counter and sticky overflow flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ref_cnt_r <= '0;
		else if (start_wr_fall || start_wr_rise || (slot_end && slot_idx_r != SLOT_LAST))
			ref_cnt_r <= '0;                                                // [R08] [R11]
		else if (run && sys_tick)
			ref_cnt_r <= ref_cnt_r + 16'h0001;
	end

	logic any_freq_ov;
	always_comb begin
		any_freq_ov = 1'b0;
		for (int m = 0; m < NUM_MOD; m++)
			if (run && key_tick[m] && keyen_r[m][4] && freq_r[m] == 16'hFFFF)
				any_freq_ov = 1'b1;
	end

	// control register: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
		end else begin
			if (wr_en && paddr == OFS_CTRL)
				ctrl_r <= pwdata[7:0] & CTRL_WMASK;                         // [R07] [R21]
			if (stop_scan) begin
				ctrl_r[B_SLOTOV] <= 1'b1;                                   // [R07] [R09] [R10]
			end
			if (any_freq_ov)
				ctrl_r[B_FREQOV] <= 1'b1;                                   // [R13]
			if (run && sys_tick && ref_cnt_r == 16'hFFFF)
				ctrl_r[B_REFOV] <= 1'b1;                                    // [R14]
		end
	end

	// one-cycle request, raised only by a hardware overflow, never by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_r <= 1'b0;
		else
			irq_r <= stop_scan;                                             // [R07]
	end
	assign module_irq_request = irq_r;

	// preload and clock configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preload_r <= PRELOAD_RST;
			clkcfg_r  <= CLKCFG_RST;
		end else if (wr_en && paddr == OFS_PRELOAD) begin
			preload_r <= pwdata[7:0];
		end else if (wr_en && paddr == OFS_CLKCFG) begin
			clkcfg_r <= pwdata[7:0];
		end
	end

	// per-module registers; a slot end reload wins over a host write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_r   <= '0;
			osc_r   <= '0;
			keyen_r <= '0;
			seq_r   <= '0;
		end else begin
			if (wr_en && in_mod(paddr)) begin
				case (paddr[4:2])                                           // [R01]
					MI_CAP_LO: cap_r[mod_of(paddr)][7:0] <= pwdata[7:0];
					MI_CAP_HI: cap_r[mod_of(paddr)][9:8] <= pwdata[1:0];
					MI_OSC:    osc_r[mod_of(paddr)]      <= pwdata[5:0] & OSC_WMASK;
					MI_KEYEN:  keyen_r[mod_of(paddr)]    <= pwdata[7:0] & KEYEN_WMASK;
					MI_SEQ:    seq_r[mod_of(paddr)]      <= pwdata[7:0];
					default: ;
				endcase
			end
			if (slot_end) begin
				for (int m = 0; m < NUM_MOD; m++)
					cap_r[m] <= {mem_r[{slot_idx_r + 2'h1, 3'b010}][1:0],
					             mem_r[{slot_idx_r + 2'h1, 3'b011}]};       // [R25]
			end
		end
	end

	// data memory: host port gated by ownership, scanner stores counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < (1<<MEM_AW); i++) mem_r[i] <= '0;
		end else begin
			if (wr_en && paddr >= OFS_MEM_BASE && paddr < OFS_MEM_END
			    && !scanner_owns)
				mem_r[paddr[MEM_AW+1:2]] <= pwdata[7:0];                    // [R04]
			// only modules 0 and 1 fit the small memory; counts stored low/high
			if (auto_r && busy_r && (slot_end || auto_done)) begin
				for (int m = 0; m < 2; m++) begin
					mem_r[{slot_idx_r, m[0], 2'b00}] <= freq_r[m][7:0];     // [R17]
					mem_r[{slot_idx_r, m[0], 2'b01}] <= freq_r[m][15:8];
				end
			end
		end
	end

	// apb read mux
	always_comb begin
		rd_byte = 8'h00;
		hit     = 1'b1;
		if (paddr == OFS_PRELOAD) rd_byte = preload_r;
		else if (paddr == OFS_CTRL) rd_byte = {ctrl_r[7:1], busy_r};        // [R19]
		else if (paddr == OFS_CLKCFG) rd_byte = clkcfg_r;
		else if (paddr == OFS_REF_LO) rd_byte = ref_cnt_r[7:0];
		else if (paddr == OFS_REF_HI) rd_byte = ref_cnt_r[15:8];
		else if (in_mod(paddr) && mod_of(paddr) < 3'(NUM_MOD)) begin
			case (paddr[4:2])
				MI_FREQ_LO: rd_byte = freq_r[mod_of(paddr)][7:0];
				MI_FREQ_HI: rd_byte = freq_r[mod_of(paddr)][15:8];
				MI_CAP_LO:  rd_byte = cap_r[mod_of(paddr)][7:0];
				MI_CAP_HI:  rd_byte = {6'h00, cap_r[mod_of(paddr)][9:8]};
				MI_OSC:     rd_byte = {2'h0, osc_r[mod_of(paddr)]};
				MI_KEYEN:   rd_byte = keyen_r[mod_of(paddr)];
				MI_SEQ:     rd_byte = seq_r[mod_of(paddr)];
				default:    hit = 1'b0;
			endcase
		end else if (paddr >= OFS_MEM_BASE && paddr < OFS_MEM_END)
			rd_byte = scanner_owns ? 8'h00 : mem_r[paddr[MEM_AW+1:2]];
		else hit = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= '0;
		else if (psel && !penable && !pwrite) prdata <= {24'h000000, rd_byte};
	end
	assign pslverr = psel & penable & ~hit;
endmodule : tks_scan_ctrl

// file: verif/tks_osc_model.sv
// tks_osc_model: key and reference oscillators on the sensor pads.
// assumes the run enables come from the scan controller; edges are pclk based.
`timescale 1ns/1ps
module tks_osc_model
	import tks_pkg::*;
(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// run enables
	input  wire logic [NUM_MOD-1:0] key_osc_run,
	input  wire logic [NUM_MOD-1:0] ref_osc_run,
	// oscillator levels
	output logic      [NUM_MOD-1:0] key_osc_edge,
	output logic      [NUM_MOD-1:0] ref_osc_edge
);
	logic [2:0] ph_r;
	// a stopped oscillator sits low instead of freezing mid-cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r         <= 3'h0;
			key_osc_edge <= '0;
			ref_osc_edge <= '0;
		end else begin
			ph_r         <= ph_r + 3'h1;
			key_osc_edge <= key_osc_run & {NUM_MOD{ph_r[1]}};
			ref_osc_edge <= ref_osc_run & {NUM_MOD{ph_r[2]}};
		end
	end
endmodule : tks_osc_model

// file: verif/tks_scan_ctrl_asserts.sv
// tks_scan_ctrl_asserts: port level checks of the scan controller.
// assumes zero wait state apb and a one-cycle interrupt pulse.
`timescale 1ns/1ps
module tks_scan_ctrl_asserts
	import tks_pkg::*;
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [NUM_MOD-1:0] key_osc_run,
	input wire logic [NUM_MOD-1:0] ref_osc_run,
	input wire logic               module_irq_request
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic wr_start;
	logic rd_ctrl;
	assign acc      = psel && penable;
	assign wr_start = acc && pwrite && paddr == OFS_CTRL && pwdata[B_START];
	assign rd_ctrl  = acc && !pwrite && paddr == OFS_CTRL;
	a_pready_zero_wait: assert property (psel |-> pready)
		else $error("pready low during a transfer");
	a_unmapped_err: assert property (acc && paddr >= 12'h014 && paddr <= 12'h03C |-> pslverr)
		else $error("no error on unmapped address");
	a_ctrl_bit2_zero: assert property (rd_ctrl |-> prdata[2] == 1'b0)
		else $error("control bit 2 read as one");
	a_ctrl_upper_zero: assert property (rd_ctrl |-> prdata[31:8] == 24'h0)
		else $error("control upper bits not zero");
	a_irq_one_pulse: assert property (module_irq_request |=> !module_irq_request)
		else $error("interrupt request longer than one cycle");
	a_irq_stops_osc: assert property (module_irq_request |-> ##[0:2]
		(key_osc_run == '0 && ref_osc_run == '0))
		else $error("oscillators still run after scan end");
	a_osc_after_start: assert property ($rose(key_osc_run[0]) |->
		($past(wr_start) || $past(wr_start, 2)))
		else $error("oscillator started without a start write");
	a_sw_flag_no_irq: assert property (acc && pwrite && paddr == OFS_CTRL && pwdata[B_SLOTOV]
		&& !pwdata[B_START] && key_osc_run == '0 |=> !module_irq_request [*3])
		else $error("software flag write raised an interrupt");
endmodule : tks_scan_ctrl_asserts
bind tks_scan_ctrl tks_scan_ctrl_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .key_osc_run(key_osc_run),
	.ref_osc_run(ref_osc_run), .module_irq_request(module_irq_request));

// file: verif/touch_key_scan_control_bench.sv
// touch_key_scan_control_bench: apb register, manual scan and auto scan tests.
// assumes the oscillator model on the pad side and pclk/4 slot clocking.
`timescale 1ns/1ps
module touch_key_scan_control_bench;
	import tks_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, q;
	logic               e;
	logic [NUM_MOD-1:0] kedge, redge, krun, rrun;
	logic [NUM_MOD-1:0] [1:0] ksel;
	logic [NUM_MOD-1:0] [9:0] rcap;
	int                 errors, total_checks, irq_cnt, cyc, n, t1;
	tks_scan_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_osc_edge(kedge), .ref_osc_edge(redge), .key_osc_run(krun),
		.ref_osc_run(rrun), .key_select(ksel), .ref_cap_setting(rcap),
		.module_irq_request(irq));
	tks_osc_model osc_u (.pclk(pclk), .presetn(presetn), .key_osc_run(krun),
		.ref_osc_run(rrun), .key_osc_edge(kedge), .ref_osc_edge(redge));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	task close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	// called just after a rising edge; returns one edge after release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task scan(input logic [7:0] pl);
		int t0, ex;
		ex = (256 - pl) * 32 * SYS_DIV;
		apb(1, OFS_CLKCFG, 32'h13);
		apb(1, OFS_PRELOAD, {24'h0, pl});
		apb(1, OFS_MOD_BASE + 12'h014, 32'hB0);
		apb(1, OFS_MOD_BASE + 12'h008, 32'h55);
		apb(1, OFS_CTRL, 32'h02);
		n = irq_cnt;
		t0 = cyc;
		apb(1, OFS_CTRL, 32'h22);
		apb(0, OFS_CTRL, 0); `CHK("busy_set", 8'h23, q[7:0])
		do apb(0, OFS_CTRL, 0); while (q[0] === 1'b1 && cyc - t0 < ex + 200);
		`CHK("scan_len", 1'b1, (cyc - t0 >= ex - 8 && cyc - t0 <= ex + 40))
		`CHK("ctrl_end", 8'h62, q[7:0])
		`CHK("irq_cnt", n + 1, irq_cnt)
		`CHK("osc_stop", 6'h00, krun)
		apb(0, OFS_MOD_BASE, 0); `CHK("freq_run", 1'b1, (q != 0))
		apb(1, OFS_CTRL, 32'h02);
		apb(0, OFS_MOD_BASE, 0); `CHK("freq_clr", 32'h0, q)
		apb(0, OFS_REF_LO, 0); `CHK("ref_clr", 32'h0, q)
		$display("test scan %0h done", pl);
	endtask : scan
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		close_out();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{errors, total_checks, irq_cnt, cyc} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, OFS_PRELOAD, 0); `CHK("preload_rst", 32'h0, q)
		apb(0, OFS_CTRL, 0); `CHK("ctrl_rst", 32'h0, q)
		apb(0, OFS_CLKCFG, 0); `CHK("clkcfg_rst", {24'h0, CLKCFG_RST}, q)
		apb(0, OFS_REF_HI, 0); `CHK("ref_rst", 32'h0, q)
		apb(0, OFS_MOD_BASE + 12'h005 * OFS_MOD_STEP, 0); `CHK("m5_rst", 32'h0, q)
		apb(0, 12'h014, 0); `CHK("unmapped_err", 1'b1, e)
		`CHK("unmapped_data", 32'h0, q)
		$display("test reset done");
		apb(1, OFS_CTRL, 32'h04);
		apb(0, OFS_CTRL, 0); `CHK("bit2", 32'h0, q)
		n = irq_cnt;
		apb(1, OFS_CTRL, 32'h58);
		apb(0, OFS_CTRL, 0); `CHK("sw_flags", 32'h58, q)
		`CHK("sw_no_irq", n, irq_cnt)
		apb(1, OFS_CTRL, 32'h00);
		apb(1, OFS_MEM_BASE, 32'hA5);
		apb(0, OFS_MEM_BASE, 0); `CHK("mem_host", 32'hA5, q)
		apb(1, OFS_CTRL, 32'h80);
		apb(0, OFS_MEM_BASE, 0); `CHK("mem_scan", 32'h0, q)
		apb(1, OFS_CTRL, 32'h00);
		$display("test flags done");
		scan(8'hF8);
		scan(8'hFE);
		apb(1, OFS_CTRL, 32'h80);
		apb(1, OFS_PRELOAD, 32'hFE);
		n = irq_cnt;
		t1 = cyc;
		apb(1, OFS_CTRL, 32'hA0);
		apb(1, OFS_CTRL, 32'h20);
		apb(0, OFS_MEM_BASE, 0); `CHK("mem_auto_own", 32'h0, q)
		do apb(0, OFS_CTRL, 0); while (q[0] === 1'b1 && cyc - t1 < 1300);
		`CHK("auto_len", 1'b1, (cyc - t1 >= 4 * 64 * SYS_DIV - 8 && cyc - t1 <= 4 * 64 * SYS_DIV + 40))
		`CHK("auto_end", 8'h60, q[7:0])
		`CHK("auto_irq", n + 1, irq_cnt)
		apb(1, OFS_CTRL, 32'h00);
		apb(0, OFS_MEM_BASE, 0); `CHK("auto_store", 1'b1, (q != 0 && q != 32'hA5))
		$display("test auto scan done");
		close_out();
	end
endmodule : touch_key_scan_control_bench
